// ===== pkg/snep_consts.svh
`ifndef SNEP_CONSTS_SVH
`define SNEP_CONSTS_SVH

// ---------------------------------------------------------------
// command opcodes
// ---------------------------------------------------------------
`define SNEP_OP_WREN      8'h06
`define SNEP_OP_WRDI      8'h04
`define SNEP_OP_ERASE     8'hd8
`define SNEP_OP_LOAD      8'h02
`define SNEP_OP_RLOAD     8'h84
`define SNEP_OP_QLOAD     8'h32
`define SNEP_OP_QRLOAD    8'h34
`define SNEP_OP_PEXEC     8'h10

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define SNEP_ONE_BYTE     3'd1
`define SNEP_ADDR_BYTES   3'd4
`define SNEP_LOAD_HDR     3'd3
`define SNEP_CNT_MAX      3'd7

// ---------------------------------------------------------------
// buffer and array geometry
// ---------------------------------------------------------------
`define SNEP_BUF_BYTES    12'd2112
`define SNEP_USER_BYTES   12'd2048
`define SNEP_NUM_BLOCKS   12'd512
`define SNEP_ALL_BLOCKS   11'd1024
`define SNEP_BP_ALL       4'd10
`define SNEP_ERASED_BYTE  8'hff
`define SNEP_PAR_OFS      4'h8

// ---------------------------------------------------------------
// configuration reset values
// ---------------------------------------------------------------
`define SNEP_RST_TB       1'b1
`define SNEP_RST_BP       4'hf
`define SNEP_RST_ECC      1'b1
`define SNEP_RST_WPE      1'b0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SNEP_CLK_MHZ          50
`define SNEP_ERASE_TIME_US    2000
`define SNEP_PROG_TIME_US     250

`endif

// ===== pkg/snep_pkg.sv
package snep_pkg;

  typedef enum logic [1:0] {
    SNEP_IDLE,
    SNEP_ERASING,
    SNEP_PROGRAMMING
  } snep_state_t;

endpackage

// ===== src/snep_flash_seq.sv
`timescale 1ns/1ps
`include "snep_consts.svh"

// ---------------------------------------------------------------
// Overview of operation
// - erase frame: D8h, one dummy byte, sixteen-bit page address
// - erase clears the whole 64-page block to FFh
// - erase ignored unless write enable latch set
// - erase runs only if chip select rises on a byte boundary
// - erase is self-timed, busy high meanwhile, low when done
// - erase or program completion clears the write enable latch
// - erase of a protected block is skipped
// - loads use 02h or 84h, column address bits 11:0, data
// - loads rejected unless write enable latch set
// - data bytes beyond 2112 are dropped
// - full loads fill unwritten bytes with FFh, random loads keep them
// - quad loads 32h and 34h take data on four lines
// - with ECC on, parity bytes of spare area are replaced
// - quad commands refused while write protect enable is set
// - program execute frame: 10h, dummy byte, page address
// - program execute writes 2112 bytes, parity substituted with ECC
// - program is self-timed, busy high meanwhile, low when done
// - program of a protected page is skipped
// - opcode 06h sets the write enable latch
// - protect bits, select and ECC enable reset to one
// - busy and latch stay readable during erase or program
// ---------------------------------------------------------------

module snep_flash_seq #(
  parameter int unsigned ERASE_CYCLES =
    `SNEP_ERASE_TIME_US * `SNEP_CLK_MHZ,
  parameter int unsigned PROG_CYCLES  =
    `SNEP_PROG_TIME_US * `SNEP_CLK_MHZ
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // link
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic [3:0]  ioIn,
  // configuration write
  input  wire logic        cfgWr,
  input  wire logic        cfgTb,
  input  wire logic [3:0]  cfgBp,
  input  wire logic        cfgEcc,
  input  wire logic        cfgWpe,
  // status
  output logic             busy,
  output logic             writeEnableLatch,
  output logic             topBottomProtectSelect,
  output logic [3:0]       blockProtectBits,
  output logic             eccEnable,
  output logic             writeProtectPinEnable,
  // array side
  output logic             eraseStart,
  output logic [15:0]      erasePage,
  output logic             pgmValid,
  output logic [15:0]      pgmPage,
  output logic [11:0]      pgmCol,
  output logic [7:0]       pgmData
);

  localparam int BUF_DEPTH = 2112;

  if (ERASE_CYCLES < 1 || ERASE_CYCLES >= 2**24) begin : g_bad_erase
    $error("ERASE_CYCLES out of range");
  end
  if (PROG_CYCLES < BUF_DEPTH + 4 || PROG_CYCLES >= 2**24) begin : g_bad_pgm
    $error("PROG_CYCLES must cover the buffer walk");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // protected span grows by powers of two from the top or bottom
  function automatic logic isProtected(input logic [15:0] page,
                                       input logic        tb,
                                       input logic [3:0]  bp);
    logic [11:0] blk;
    logic [10:0] span;
    blk  = {2'b00, page[15:6]};
    span = (bp > `SNEP_BP_ALL) ? `SNEP_ALL_BLOCKS
                               : (11'd1 << (bp - 4'd1));
    if (bp == 4'd0) begin
      isProtected = 1'b0;
    end else if (tb) begin
      isProtected = (blk < {1'b0, span});
    end else begin
      isProtected = (blk + {1'b0, span} >= `SNEP_NUM_BLOCKS);
    end
  endfunction

  function automatic logic isLoadOp(input logic [7:0] op);
    isLoadOp = (op == `SNEP_OP_LOAD) || (op == `SNEP_OP_RLOAD) ||
               (op == `SNEP_OP_QLOAD) || (op == `SNEP_OP_QRLOAD);
  endfunction

  function automatic logic isQuadOp(input logic [7:0] op);
    isQuadOp = (op == `SNEP_OP_QLOAD) || (op == `SNEP_OP_QRLOAD);
  endfunction

  // ---------------------------------------------------------------
  // link domain front end
  // ---------------------------------------------------------------
  logic [7:0] linkByte;
  logic       linkTgl;
  logic       linkMid;

  snep_spi_link u_link (
    .sclk     (sclk),
    .csN      (csN),
    .rst      (rst),
    .ioIn     (ioIn),
    .byteData (linkByte),
    .byteTgl  (linkTgl),
    .midByte  (linkMid)
  );

  // ---------------------------------------------------------------
  // crossings into clk
  // ---------------------------------------------------------------
  logic csMeta_reg;
  logic csSync_reg;
  logic csDly_reg;
  logic tglMeta_reg;
  logic tglSync_reg;
  logic tglSeen_reg;
  logic midMeta_reg;
  logic midSync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csMeta_reg  <= 1'b1;
      csSync_reg  <= 1'b1;
      csDly_reg   <= 1'b1;
      tglMeta_reg <= 1'b0;
      tglSync_reg <= 1'b0;
      tglSeen_reg <= 1'b0;
      midMeta_reg <= 1'b0;
      midSync_reg <= 1'b0;
    end else begin
      csMeta_reg  <= csN;
      csSync_reg  <= csMeta_reg;
      csDly_reg   <= csSync_reg;
      tglMeta_reg <= linkTgl;
      tglSync_reg <= tglMeta_reg;
      tglSeen_reg <= tglSync_reg;
      midMeta_reg <= linkMid;
      midSync_reg <= midMeta_reg;
    end
  end

  // linkByte is held for a whole byte time after its toggle, so it
  // is stable long before the synchronised toggle is seen here
  wire frameStart = csDly_reg & ~csSync_reg;
  wire frameEnd   = ~csDly_reg & csSync_reg;
  wire byteEv     = tglSync_reg ^ tglSeen_reg;

  // ---------------------------------------------------------------
  // command framing
  // ---------------------------------------------------------------
  snep_pkg::snep_state_t state_reg;
  snep_pkg::snep_state_t state_next;

  logic [2:0]  byteCnt_reg;
  logic [7:0]  opcode_reg;
  logic [15:0] addr_reg;
  logic [11:0] col_reg;
  logic        loadOk_reg;

  wire idle      = (state_reg == snep_pkg::SNEP_IDLE);
  wire firstByte = byteEv && (byteCnt_reg == 3'd0);
  wire dataByte  = byteEv && (byteCnt_reg >= `SNEP_LOAD_HDR);
  wire loadAccept = idle && writeEnableLatch &&
                    isLoadOp(linkByte) &&
                    !(isQuadOp(linkByte) && writeProtectPinEnable);
  wire fillClr = firstByte && loadAccept &&
                 ((linkByte == `SNEP_OP_LOAD) ||
                  (linkByte == `SNEP_OP_QLOAD));
  wire bufWe = dataByte && loadOk_reg &&
               (col_reg < `SNEP_BUF_BYTES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byteCnt_reg <= 3'd0;
      opcode_reg  <= 8'h00;
      addr_reg    <= 16'h0000;
      col_reg     <= 12'h000;
      loadOk_reg  <= 1'b0;
    end else if (frameStart) begin
      byteCnt_reg <= 3'd0;
      loadOk_reg  <= 1'b0;
    end else if (byteEv) begin
      if (byteCnt_reg != `SNEP_CNT_MAX) begin
        byteCnt_reg <= byteCnt_reg + 3'd1;
      end
      if (byteCnt_reg == 3'd0) begin
        opcode_reg <= linkByte;
        loadOk_reg <= loadAccept;
      end else if (byteCnt_reg < `SNEP_ADDR_BYTES) begin
        addr_reg <= {addr_reg[7:0], linkByte};
      end
      if (byteCnt_reg == 3'd2) begin
        col_reg <= {addr_reg[3:0], linkByte};
      end else if (bufWe) begin
        col_reg <= col_reg + 12'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // frame end decode
  // ---------------------------------------------------------------
  wire oneByte   = (byteCnt_reg == `SNEP_ONE_BYTE) && !midSync_reg;
  wire addrFrame = (byteCnt_reg == `SNEP_ADDR_BYTES) &&
                   !midSync_reg;
  wire pageProt  = isProtected(addr_reg, topBottomProtectSelect,
                               blockProtectBits);
  wire cmdWren   = frameEnd && idle && oneByte &&
                   (opcode_reg == `SNEP_OP_WREN);
  wire cmdWrdi   = frameEnd && idle && oneByte &&
                   (opcode_reg == `SNEP_OP_WRDI);
  wire goErase   = frameEnd && idle && addrFrame &&
                   (opcode_reg == `SNEP_OP_ERASE) &&
                   writeEnableLatch &&
                   !pageProt;
  wire goProg    = frameEnd && idle && addrFrame &&
                   (opcode_reg == `SNEP_OP_PEXEC) &&
                   writeEnableLatch &&
                   !pageProt;

  // ---------------------------------------------------------------
  // self-timed cycles
  // ---------------------------------------------------------------
  localparam logic [23:0] ERASE_LAST = 24'(ERASE_CYCLES - 1);
  localparam logic [23:0] PROG_LAST  = 24'(PROG_CYCLES - 1);

  logic [23:0] timer_reg;
  wire         cycDone = !idle && (timer_reg == 24'd0);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      snep_pkg::SNEP_IDLE: begin
        if (goErase) begin
          state_next = snep_pkg::SNEP_ERASING;
        end else if (goProg) begin
          state_next = snep_pkg::SNEP_PROGRAMMING;
        end
      end
      snep_pkg::SNEP_ERASING,
      snep_pkg::SNEP_PROGRAMMING: begin
        if (cycDone) begin
          state_next = snep_pkg::SNEP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= snep_pkg::SNEP_IDLE;
      timer_reg <= 24'd0;
    end else begin
      state_reg <= state_next;
      if (goErase) begin
        timer_reg <= ERASE_LAST;
      end else if (goProg) begin
        timer_reg <= PROG_LAST;
      end else if (!cycDone && !idle) begin
        timer_reg <= timer_reg - 24'd1;
      end
    end
  end

  // busy comes straight from the state so status polls see it live
  assign busy = !idle;

  // ---------------------------------------------------------------
  // write enable latch and configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeEnableLatch       <= 1'b0;
      topBottomProtectSelect <= `SNEP_RST_TB;
      blockProtectBits       <= `SNEP_RST_BP;
      eccEnable              <= `SNEP_RST_ECC;
      writeProtectPinEnable  <= `SNEP_RST_WPE;
    end else begin
      // a set in the same cycle as a completion wins
      if (cmdWren) begin
        writeEnableLatch <= 1'b1;
      end else if (cycDone || cmdWrdi) begin
        writeEnableLatch <= 1'b0;
      end
      if (cfgWr) begin
        topBottomProtectSelect <= cfgTb;
        blockProtectBits       <= cfgBp;
        eccEnable              <= cfgEcc;
        writeProtectPinEnable  <= cfgWpe;
      end
    end
  end

  // ---------------------------------------------------------------
  // page buffer
  // ---------------------------------------------------------------
  logic [7:0]           bufMem [0:BUF_DEPTH-1];
  logic [BUF_DEPTH-1:0] filled_reg;
  logic [11:0]          walkIdx_reg;
  logic [7:0]           rdByte_reg;
  logic                 rdFill_reg;
  logic                 rdVal_reg;
  logic [11:0]          rdCol_reg;

  wire        walkOn = (state_reg == snep_pkg::SNEP_PROGRAMMING) &&
                       (walkIdx_reg < `SNEP_BUF_BYTES);
  wire [11:0] rdAddr = walkOn ? walkIdx_reg : 12'h000;

  always_ff @(posedge clk) begin
    if (bufWe) begin
      bufMem[col_reg] <= linkByte;
    end
    rdByte_reg <= bufMem[rdAddr];
  end

  // unfilled bytes read as erased, so a full load needs no sweep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filled_reg <= '0;
      rdFill_reg <= 1'b0;
    end else begin
      if (fillClr) begin
        filled_reg <= '0;
      end else if (bufWe) begin
        filled_reg[col_reg] <= 1'b1;
      end
      rdFill_reg <= filled_reg[rdAddr];
    end
  end

  // ---------------------------------------------------------------
  // program walk with parity substitution
  // ---------------------------------------------------------------
  logic [7:0] secPar_reg [0:3];

  wire [7:0] byteVal = rdFill_reg ? rdByte_reg : `SNEP_ERASED_BYTE;
  wire       userCol = (rdCol_reg < `SNEP_USER_BYTES);
  wire       parPos  = eccEnable && !userCol &&
                       (rdCol_reg[3:0] == `SNEP_PAR_OFS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      walkIdx_reg <= 12'h000;
      rdVal_reg   <= 1'b0;
      rdCol_reg   <= 12'h000;
      for (int i = 0; i < 4; i++) begin
        secPar_reg[i] <= 8'h00;
      end
    end else begin
      rdVal_reg <= walkOn;
      rdCol_reg <= walkIdx_reg;
      if (goProg) begin
        walkIdx_reg <= 12'h000;
        for (int i = 0; i < 4; i++) begin
          secPar_reg[i] <= 8'h00;
        end
      end else begin
        if (walkOn) begin
          walkIdx_reg <= walkIdx_reg + 12'd1;
        end
        if (rdVal_reg && userCol) begin
          secPar_reg[rdCol_reg[10:9]] <=
            secPar_reg[rdCol_reg[10:9]] ^ byteVal;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // array outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eraseStart <= 1'b0;
      erasePage  <= 16'h0000;
      pgmValid   <= 1'b0;
      pgmPage    <= 16'h0000;
      pgmCol     <= 12'h000;
      pgmData    <= 8'h00;
    end else begin
      eraseStart <= goErase;
      if (goErase) begin
        erasePage <= {addr_reg[15:6], 6'h00};
      end
      if (goProg) begin
        pgmPage <= addr_reg;
      end
      pgmValid <= rdVal_reg;
      pgmCol   <= rdCol_reg;
      pgmData  <= parPos ? secPar_reg[rdCol_reg[5:4]]
                         : byteVal;
    end
  end

endmodule

// ===== src/snep_spi_link.sv
`timescale 1ns/1ps
`include "snep_consts.svh"

module snep_spi_link (
  // link
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       rst,
  input  wire logic [3:0] ioIn,
  // to core
  output logic [7:0]      byteData,
  output logic            byteTgl,
  output logic            midByte
);

  // ---------------------------------------------------------------
  // frame state, cleared by chip select high
  // ---------------------------------------------------------------
  logic [2:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] hdrCnt_reg;
  logic       quadOp_reg;
  logic       quad_reg;

  wire        frameClr = rst | csN;
  wire [3:0]  cntSum   = {1'b0, bitCnt_reg} + (quad_reg ? 4'd4 : 4'd1);
  wire        byteDone = cntSum[3];
  wire [7:0]  shiftNext = quad_reg ? {shift_reg[3:0], ioIn}
                                   : {shift_reg[6:0], ioIn[0]};
  wire        isQuadOp = (shiftNext == `SNEP_OP_QLOAD) ||
                         (shiftNext == `SNEP_OP_QRLOAD);

  always_ff @(posedge sclk or posedge frameClr) begin
    if (frameClr) begin
      bitCnt_reg <= 3'd0;
      shift_reg  <= 8'h00;
      hdrCnt_reg <= 2'd0;
      quadOp_reg <= 1'b0;
      quad_reg   <= 1'b0;
    end else begin
      bitCnt_reg <= cntSum[2:0];
      shift_reg  <= shiftNext;
      if (byteDone && hdrCnt_reg != 2'd3) begin
        hdrCnt_reg <= hdrCnt_reg + 2'd1;
      end
      if (byteDone && hdrCnt_reg == 2'd0) begin
        quadOp_reg <= isQuadOp;
      end
      // data phase of quad loads arrives on all four lines
      if (byteDone && hdrCnt_reg == 2'd2 && quadOp_reg) begin
        quad_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // byte hand-off; toggle survives the frame so no false event
  // ---------------------------------------------------------------
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      byteData <= 8'h00;
      byteTgl  <= 1'b0;
      midByte  <= 1'b0;
    end else begin
      midByte <= (cntSum[2:0] != 3'd0);
      if (byteDone) begin
        byteData <= shiftNext;
        byteTgl  <= ~byteTgl;
      end
    end
  end

endmodule

// ===== tb/snep_flash_seq_assertions.sv
`timescale 1ns/1ps
module snep_flash_seq_assertions #(
  parameter int unsigned ERASE_CYCLES = 50,
  parameter int unsigned PROG_CYCLES  = 2200
) (
  // system
  input wire logic        clk,
  input wire logic        rst,
  // status
  input wire logic        busy,
  input wire logic        writeEnableLatch,
  input wire logic [3:0]  blockProtectBits,
  // array side
  input wire logic        eraseStart,
  input wire logic [15:0] erasePage,
  input wire logic        pgmValid,
  input wire logic [15:0] pgmPage,
  input wire logic [11:0] pgmCol
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // busy length helper
  // ---------------------------------------------------------------
  logic [31:0] busyCnt_reg;
  logic [31:0] busyCnt_next;
  logic        isErase_reg;
  logic        isErase_next;
  assign busyCnt_next = busy ? busyCnt_reg + 32'h1 : 32'h0;
  // kind is kept until busy drops so the fall edge still knows it
  assign isErase_next = eraseStart | (busy & isErase_reg);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_reg <= 32'h0;
      isErase_reg <= 1'b0;
    end else begin
      busyCnt_reg <= busyCnt_next;
      isErase_reg <= isErase_next;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_erase_gate;
    eraseStart |-> writeEnableLatch && blockProtectBits < 4'ha;
  endproperty
  a_erase_gate: assert property (p_erase_gate)
    else $error("erase started without latch or inside protection");
  property p_erase_busy;
    eraseStart |=> busy;
  endproperty
  a_erase_busy: assert property (p_erase_busy)
    else $error("busy not high after erase start");
  property p_erase_align;
    eraseStart |-> erasePage[5:0] == 6'h00;
  endproperty
  a_erase_align: assert property (p_erase_align)
    else $error("erase page not block aligned");
  property p_busy_len;
    $fell(busy) |->
      busyCnt_reg == (isErase_reg ? ERASE_CYCLES : PROG_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_wel_clear;
    $fell(busy) |-> !writeEnableLatch;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch not cleared at completion");
  property p_pgm_first;
    $rose(pgmValid) |->
      busy && pgmCol == 12'h000 && $past(busy, 2) && !$past(busy, 3);
  endproperty
  a_pgm_first: assert property (p_pgm_first)
    else $error("program stream start wrong");
  property p_pgm_step;
    pgmValid && pgmCol != 12'h83f |=>
      pgmValid && pgmCol == $past(pgmCol) + 12'h001;
  endproperty
  a_pgm_step: assert property (p_pgm_step)
    else $error("program stream not consecutive");
  property p_pgm_last;
    pgmValid && pgmCol == 12'h83f |=> !pgmValid;
  endproperty
  a_pgm_last: assert property (p_pgm_last)
    else $error("program stream runs past last column");
  property p_pgm_prot;
    pgmValid |-> blockProtectBits < 4'ha && $stable(pgmPage);
  endproperty
  a_pgm_prot: assert property (p_pgm_prot)
    else $error("program while fully protected or page moved");

  c_erase: cover property (eraseStart);
  c_pgm_end: cover property (pgmValid && pgmCol == 12'h83f);
  c_erase_done: cover property ($fell(busy) && isErase_reg);
endmodule

bind snep_flash_seq snep_flash_seq_assertions #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES (PROG_CYCLES)
) u_snep_flash_seq_assertions (
  .clk(clk), .rst(rst), .busy(busy),
  .writeEnableLatch(writeEnableLatch),
  .blockProtectBits(blockProtectBits), .eraseStart(eraseStart),
  .erasePage(erasePage), .pgmValid(pgmValid), .pgmPage(pgmPage),
  .pgmCol(pgmCol)
);

// ===== tb/snep_host_model.sv
`timescale 1ns/1ps
module snep_host_model (
  // link
  output logic       sclk,
  output logic       csN,
  output logic [3:0] ioIn
);
  localparam int HALF = 80;
  logic [7:0] txq [$];
  int         quadFrom = 99;
  int         extraBits = 0;
  logic [3:0] lastIo;

  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    ioIn = 4'h0;
    lastIo = 4'h0;
  end

  // data changes while sclk is low, taken at the rise
  task automatic putBits(input logic [3:0] v);
    ioIn = v;
    lastIo = v;
    #HALF sclk = 1'b1;
    #HALF sclk = 1'b0;
  endtask

  // whole frame under one low chip select
  task automatic runFrame();
    int i;
    int b;
    csN = 1'b0;
    #HALF;
    for (i = 0; i < txq.size(); i++) begin
      if (i >= quadFrom) begin
        putBits(txq[i][7:4]);
        putBits(txq[i][3:0]);
      end else begin
        for (b = 7; b >= 0; b--) begin
          putBits({{3{~txq[i][b]}}, txq[i][b]});
        end
      end
    end
    for (i = 0; i < extraBits; i++) begin
      putBits(4'h1);
    end
    #HALF csN = 1'b1;
    // released lines must not keep showing the last value
    ioIn = ~lastIo;
    #(HALF * 4);
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic        wren;
    logic        tbSel;
    logic [3:0]  bp;
    logic [15:0] page;
    logic        go;
  } snep_erow_t;
  logic        clk;
  logic        rst;
  logic        cfgWr;
  logic        cfgTb;
  logic [3:0]  cfgBp;
  logic        cfgEcc;
  logic        cfgWpe;
  wire logic   sclk;
  wire logic   csN;
  wire logic [3:0] ioIn;
  logic        busy;
  logic        writeEnableLatch;
  logic        topBottomProtectSelect;
  logic [3:0]  blockProtectBits;
  logic        eccEnable;
  logic        writeProtectPinEnable;
  logic        eraseStart;
  logic [15:0] erasePage;
  logic        pgmValid;
  logic [15:0] pgmPage;
  logic [11:0] pgmCol;
  logic [7:0]  pgmData;
  logic [7:0]  cap [0:2111];
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          eraseCnt = 0;
  int          pgmCnt = 0;
  snep_erow_t  rows [5] = '{
    '{1'b1, 1'b1, 4'h0, 16'h0041, 1'b1},
    '{1'b0, 1'b1, 4'h0, 16'h0080, 1'b0},
    '{1'b1, 1'b1, 4'h1, 16'h0000, 1'b0},
    '{1'b1, 1'b1, 4'h1, 16'h0040, 1'b1},
    '{1'b1, 1'b0, 4'h2, 16'h7f80, 1'b0}};

  snep_flash_seq #(.ERASE_CYCLES(50), .PROG_CYCLES(2200)) u_snep_flash_seq (
    .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .ioIn(ioIn),
    .cfgWr(cfgWr), .cfgTb(cfgTb), .cfgBp(cfgBp), .cfgEcc(cfgEcc),
    .cfgWpe(cfgWpe), .busy(busy), .writeEnableLatch(writeEnableLatch),
    .topBottomProtectSelect(topBottomProtectSelect),
    .blockProtectBits(blockProtectBits), .eccEnable(eccEnable),
    .writeProtectPinEnable(writeProtectPinEnable),
    .eraseStart(eraseStart), .erasePage(erasePage),
    .pgmValid(pgmValid), .pgmPage(pgmPage), .pgmCol(pgmCol),
    .pgmData(pgmData));
  snep_host_model u_snep_host_model (.sclk(sclk), .csN(csN), .ioIn(ioIn));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (eraseStart === 1'b1) eraseCnt++;
    if (pgmValid === 1'b1) begin
      cap[pgmCol] = pgmData;
      pgmCnt++;
    end
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bytes are taken from the top of w; quad data from byte index q on
  task automatic send(input logic [39:0] w, input int n, q, x = 0);
    int i;
    u_snep_host_model.txq.delete();
    for (i = 0; i < n; i++) u_snep_host_model.txq.push_back(w[39-8*i -: 8]);
    u_snep_host_model.quadFrom = q;
    u_snep_host_model.extraBits = x;
    u_snep_host_model.runFrame();
    repeat (8) @(posedge clk);
  endtask

  task automatic cfg(input logic t, input logic [3:0] b, input logic e, w);
    @(posedge clk);
    cfgTb <= t;
    cfgBp <= b;
    cfgEcc <= e;
    cfgWpe <= w;
    cfgWr <= 1'b1;
    @(posedge clk);
    cfgWr <= 1'b0;
  endtask

  task automatic waitIdle();
    int k;
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic exec(input logic [15:0] pg);
    send({8'h06, 32'h0}, 1, 9);
    pgmCnt = 0;
    send({8'h10, 8'h00, pg, 8'h00}, 4, 9);
    waitIdle();
  endtask

  initial begin
    rst = 1'b1;
    cfgWr = 1'b0;
    cfgTb = 1'b1;
    cfgBp = 4'h0;
    cfgEcc = 1'b0;
    cfgWpe = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("tbSel", topBottomProtectSelect, 1'b1);
    chk("bp", blockProtectBits, 4'hf);
    chk("ecc", eccEnable, 1'b1);
    chk("wpe", writeProtectPinEnable, 1'b0);
    chk("latch", writeEnableLatch, 1'b0);
    $display("done: reset");
    foreach (rows[r]) begin
      cfg(rows[r].tbSel, rows[r].bp, 1'b0, 1'b0);
      if (rows[r].wren) send({8'h06, 32'h0}, 1, 9);
      eraseCnt = 0;
      send({8'hd8, 8'h00, rows[r].page, 8'h00}, 4, 9);
      waitIdle();
      chk("eraseCnt", eraseCnt, rows[r].go);
      if (rows[r].go) begin
        chk("erasePage", erasePage, rows[r].page & 16'hffc0);
        chk("latch", writeEnableLatch, 1'b0);
      end
      $display("done: erase row %0d", r);
    end
    cfg(1'b1, 4'h0, 1'b0, 1'b0);
    send({8'h06, 32'h0}, 1, 9);
    eraseCnt = 0;
    send({8'hd8, 8'h00, 16'h0100, 8'h00}, 4, 9, 3);
    waitIdle();
    chk("eraseCnt", eraseCnt, 0);
    $display("done: partial byte");
    // page 3 is skipped, so page 7 stays the only programmed page
    cfg(1'b1, 4'h1, 1'b0, 1'b0);
    exec(16'h0003);
    chk("pgmCnt", pgmCnt, 0);
    cfg(1'b1, 4'h0, 1'b0, 1'b0);
    send({8'h06, 32'h0}, 1, 9);
    send({8'h02, 8'h00, 8'h05, 8'ha5, 8'h3c}, 5, 9);
    exec(16'h0007);
    chk("pgmCnt", pgmCnt, 2112);
    chk("pgmPage", pgmPage, 16'h0007);
    chk("cap5", cap[5], 8'ha5);
    chk("cap6", cap[6], 8'h3c);
    chk("cap0", cap[0], 8'hff);
    chk("latch", writeEnableLatch, 1'b0);
    send({8'h06, 32'h0}, 1, 9);
    send({8'h34, 8'h00, 8'h06, 8'h5a, 8'h00}, 4, 3);
    exec(16'h0007);
    chk("cap5", cap[5], 8'ha5);
    chk("cap6", cap[6], 8'h5a);
    send({8'h06, 32'h0}, 1, 9);
    send({8'h32, 8'hf8, 8'h3f, 8'h11, 8'h22}, 5, 3);
    exec(16'h0007);
    chk("cap2111", cap[2111], 8'h11);
    chk("cap5", cap[5], 8'hff);
    $display("done: loads");
    // fourth partial program of page 7, within the allowed count
    send({8'h02, 8'h00, 8'h00, 8'h99, 8'h00}, 4, 9);
    cfg(1'b1, 4'h0, 1'b1, 1'b1);
    send({8'h06, 32'h0}, 1, 9);
    send({8'h32, 8'h00, 8'h00, 8'h77, 8'h00}, 4, 3);
    cfg(1'b1, 4'h0, 1'b1, 1'b0);
    exec(16'h0007);
    chk("cap0", cap[0], 8'hff);
    chk("cap2111", cap[2111], 8'h11);
    chk("parity", cap[2056], 8'h00);
    $display("done: refusals and parity");
    end_sim();
  end
endmodule
